// >>> design/qtc_pkg.sv
// Purpose: Constants, register map and carrier types of the timer set
// Assumes: 8-bit register port, one 100 MHz clock
// Notes: The instruction clock is the system clock divided by four
package qtc_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] QTC_ADR_T0_CTL = 8'h05;
	localparam logic [7:0] QTC_ADR_INTERRUPT_STATUS_ENABLE = 8'h07;
	localparam logic [7:0] QTC_ADR_T0_LO = 8'h0b;
	localparam logic [7:0] QTC_ADR_T0_HI = 8'h0c;
	localparam logic [7:0] QTC_ADR_T1_CNT = 8'h10;
	localparam logic [7:0] QTC_ADR_T1_PER = 8'h11;
	localparam logic [7:0] QTC_ADR_T2_CNT = 8'h12;
	localparam logic [7:0] QTC_ADR_T2_PER = 8'h13;
	localparam logic [7:0] QTC_ADR_T3_LO = 8'h14;
	localparam logic [7:0] QTC_ADR_T3_HI = 8'h15;
	localparam logic [7:0] QTC_ADR_P3_LO = 8'h16;
	localparam logic [7:0] QTC_ADR_P3_HI = 8'h17;
	localparam logic [7:0] QTC_ADR_C1_LO = 8'h18;
	localparam logic [7:0] QTC_ADR_C1_HI = 8'h19;
	localparam logic [7:0] QTC_ADR_TCTL = 8'h1a;
	localparam logic [7:0] QTC_ADR_TFLG = 8'h1b;
	localparam logic [7:0] QTC_ADR_TEN = 8'h1c;
	localparam logic [7:0] QTC_ADR_DUTY1 = 8'h1d;
	localparam logic [7:0] QTC_ADR_DUTY2 = 8'h1e;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int QTC_CTL_EDGE = 6;
	localparam int QTC_CTL_INTCLK = 5;
	localparam int QTC_CTL_PS_LSB = 1;
	localparam int QTC_CTL_PS_W = 4;
	localparam logic [7:0] QTC_CTL_MASK = 8'hfe;
	localparam int QTC_INT_TIMER_ZERO_OVERFLOW_FLAG = 5;
	localparam int QTC_INT_TIMER_ZERO_IRQ_ENABLE = 1;
	localparam int QTC_TC_T1_EXT = 0;
	localparam int QTC_TC_T2_EXT = 1;
	localparam int QTC_TC_JOIN = 2;
	localparam int QTC_TC_T3_EXT = 3;
	localparam int QTC_TC_DUAL = 4;
	localparam int QTC_TC_T1_ON = 5;
	localparam int QTC_TC_T2_ON = 6;
	localparam int QTC_TC_T3_ON = 7;
	localparam int QTC_FL_T1 = 0;
	localparam int QTC_FL_T2 = 1;
	localparam int QTC_FL_T3 = 2;
	localparam int QTC_FL_CAP1 = 3;
	localparam int QTC_FL_CAP2 = 4;
	localparam logic [7:0] QTC_FL_MASK = 8'h1f;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] QTC_CTL_RST = 8'h00;
	localparam logic [7:0] QTC_INTERRUPT_STATUS_ENABLE_RST = 8'h00;
	localparam logic [7:0] QTC_TCTL_RST = 8'h00;
	localparam logic [7:0] QTC_PER8_RST = 8'hff;
	localparam logic [15:0] QTC_PER16_RST = 16'hffff;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [1:0] QTC_Q_LAST = 2'h3;
	localparam logic [1:0] QTC_Q_MID = 2'h1;
	localparam int QTC_CLK_NS = 10;
	localparam int QTC_SYNC_MIN_NS = 30;
	localparam int QTC_SYNC_MAX_NS = 70;
	localparam int QTC_SYNC_MIN_CYC =
		(QTC_SYNC_MIN_NS + QTC_CLK_NS - 1) / QTC_CLK_NS;
	localparam int QTC_SYNC_MAX_CYC = QTC_SYNC_MAX_NS / QTC_CLK_NS;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} qtc_bus_t;

	typedef struct packed {
		logic timer_zero_count_pin;
		logic shared_count_pin;
		logic timer_three_count_pin;
		logic capture_one_pin;
		logic capture_two_pin;
	} qtc_pins_t;

	typedef struct packed {
		logic [1:0] q;
		logic [7:0] ctl0;
		logic [7:0] interrupt_status_enable;
		logic [15:0] timer_zero_count;
		logic [7:0] pre;
		logic prescaler_output;
		logic psync;
		logic samp;
		logic [4:0] pins_prev;
		logic [7:0] timer_one_count;
		logic [7:0] timer_two_count;
		logic [7:0] timer_one_period;
		logic [7:0] timer_two_period;
		logic [15:0] timer_three_count;
		logic [15:0] timer_three_period;
		logic [15:0] capture_one;
		logic [7:0] tctl;
		logic [7:0] tflg;
		logic [7:0] ten;
		logic [7:0] duty1;
		logic [7:0] duty2;
		logic [1:0] pwm;
		logic [7:0] rdata;
	} qtc_state_t;

endpackage

// >>> design/qtc_timers.sv
// Purpose: Four timer/counters with register port
// Assumes: Pins synchronous to clk_i; one instruction tick per 4 clocks
// Notes: All state is one struct, filled combinationally and registered
// Notes: Any timer zero write restarts its prescaler
//
// Function
// [R1] Timer zero is a 16-bit overflow counter on instruction clock or pin.
// [R2] Control bits four to one pick prescale 1:1 up to 1:256.
// [R3] Control bit five set counts internal clock, clear counts the pin.
// [R4] Control bit six set counts rising pin edges, clear falling.
// [R5] Timer zero wraps FFFFh to 0000h and sets its overflow flag.
// [R6] Clear enable masks timer zero request; the flag still sets.
// [R7] Vectoring to timer zero clears its overflow flag.
// [R8] Pin is prescaled first, then sampled twice per instruction cycle.
// [R9] Increment follows a pin edge by three to seven clock periods.
// [R10] Timer one is 8-bit with period; match-to-zero sets its flag.
// [R11] Timer two is 8-bit with period; match-to-zero sets its flag.
// [R12] Timers one and two may both count the shared pin.
// [R13] Joined, timer one is low byte, timer two high; sets flag one.
// [R14] Timer three is 16-bit with period; rollover sets its flag.
// [R15] Timer three in counter mode counts its own pin.
// [R16] Dual capture turns timer three period into second capture register.
// [R17] Timers one, two drive the pulse outputs; three times captures.
// [R18] Prescale value n up to eight divides by two to n, else 256.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module qtc_timers
	import qtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire qtc_bus_t bus_i,
	input wire qtc_pins_t pins_i,
	input wire logic t0_vector_ack_i,
	output logic [7:0] rdata_o,
	output logic [3:0] irq_o,
	output logic [1:0] pwm_o
);

	qtc_state_t st_ff;
	qtc_state_t nxt_st;

	// ----------------------------------------------------------------
	// Pin edges
	// ----------------------------------------------------------------
	wire logic [4:0] pin_rise;
	wire logic [4:0] pin_fall;

	// One edge detector per pin against last cycle's level
	for (genvar g = 0; g < 5; g++) begin : g_edge
		assign pin_rise[g] = pins_i[g] & ~st_ff.pins_prev[g];
		assign pin_fall[g] = ~pins_i[g] & st_ff.pins_prev[g];
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic tick;
		logic samp_en;
		logic [4:0] rise;
		logic [4:0] fall;
		logic t0_ev;
		logic [3:0] ps;
		logic [7:0] ps_mask;
		logic fire;
		logic inc0;
		logic t0_ovf;
		logic t1_ev;
		logic t2_ev;
		logic t3_ev;
		logic [15:0] pair;
		logic [15:0] pair_per;
		logic [15:0] t3_lim;
		logic [7:0] fl_set;
		logic [7:0] fl_clr;
		logic join16;
		logic dual;
		logic t0_wr;
		tick = 1'b0;
		samp_en = 1'b0;
		rise = '0;
		fall = '0;
		t0_ev = 1'b0;
		ps = '0;
		ps_mask = '0;
		fire = 1'b0;
		inc0 = 1'b0;
		t0_ovf = 1'b0;
		t1_ev = 1'b0;
		t2_ev = 1'b0;
		t3_ev = 1'b0;
		pair = '0;
		pair_per = '0;
		t3_lim = '0;
		fl_set = '0;
		fl_clr = '0;
		join16 = 1'b0;
		dual = 1'b0;
		t0_wr = 1'b0;
		nxt_st = st_ff;

		// --------------------------------------------------------
		// Instruction clock
		// --------------------------------------------------------
		// One tick per four system clocks, two sample points per tick
		nxt_st.q = st_ff.q + 2'h1;
		tick = (st_ff.q == QTC_Q_LAST); // [R1]
		samp_en = (st_ff.q == QTC_Q_LAST) || (st_ff.q == QTC_Q_MID);

		// Edges from the per-pin detectors; keep levels for next cycle
		rise = pin_rise;
		fall = pin_fall;
		nxt_st.pins_prev = pins_i;

		// --------------------------------------------------------
		// Timer zero source and prescaler
		// --------------------------------------------------------
		// Timer zero source: instruction tick or selected pin edge
		if (st_ff.ctl0[QTC_CTL_INTCLK]) begin
			t0_ev = tick; // [R3]
		end else if (st_ff.ctl0[QTC_CTL_EDGE]) begin
			t0_ev = rise[4]; // [R4]
		end else begin
			t0_ev = fall[4]; // [R4]
		end

		// Prescaler: fires when the low n bits roll over
		ps = st_ff.ctl0[QTC_CTL_PS_LSB +: QTC_CTL_PS_W];
		if (ps >= 4'h8) begin
			ps_mask = 8'hff; // [R18]
		end else begin
			ps_mask = 8'((9'h001 << ps) - 9'h001); // [R2] [R18]
		end
		if (t0_ev) begin
			nxt_st.pre = st_ff.pre + 8'h01;
		end
		fire = t0_ev && ((st_ff.pre & ps_mask) == ps_mask); // [R2]

		// External path: prescaled output toggles, sampled twice per cycle
		if (fire && !st_ff.ctl0[QTC_CTL_INTCLK]) begin
			nxt_st.prescaler_output = ~st_ff.prescaler_output; // [R8]
		end
		// Extra stage: first sample comes three clocks after the pin edge
		nxt_st.psync = st_ff.prescaler_output; // [R9]
		if (samp_en) begin
			nxt_st.samp = st_ff.psync; // [R8]
		end
		if (st_ff.ctl0[QTC_CTL_INTCLK]) begin
			inc0 = fire;
		end else begin
			inc0 = samp_en && (st_ff.psync != st_ff.samp); // [R9]
		end

		// --------------------------------------------------------
		// Timer zero count
		// --------------------------------------------------------
		// Timer zero counts up and wraps
		if (inc0) begin
			nxt_st.timer_zero_count = st_ff.timer_zero_count + 16'h0001; // [R1]
			t0_ovf = (st_ff.timer_zero_count == 16'hffff); // [R5]
		end

		// --------------------------------------------------------
		// Timers one and two
		// --------------------------------------------------------
		// Timers one and two sources; both may take the shared pin
		t1_ev = st_ff.tctl[QTC_TC_T1_ON] &&
			(st_ff.tctl[QTC_TC_T1_EXT] ? rise[3] : tick); // [R12]
		t2_ev = st_ff.tctl[QTC_TC_T2_ON] &&
			(st_ff.tctl[QTC_TC_T2_EXT] ? rise[3] : tick); // [R12]
		join16 = st_ff.tctl[QTC_TC_JOIN];
		pair = {st_ff.timer_two_count, st_ff.timer_one_count};
		pair_per = {st_ff.timer_two_period, st_ff.timer_one_period};
		if (join16) begin
			if (t1_ev) begin
				if (pair == pair_per) begin
					nxt_st.timer_one_count = 8'h00; // [R13]
					nxt_st.timer_two_count = 8'h00;
					fl_set[QTC_FL_T1] = 1'b1; // [R13]
				end else begin
					pair = pair + 16'h0001;
					nxt_st.timer_one_count = pair[7:0]; // [R13]
					nxt_st.timer_two_count = pair[15:8];
				end
			end
		end else begin
			if (t1_ev) begin
				if (st_ff.timer_one_count == st_ff.timer_one_period) begin
					nxt_st.timer_one_count = 8'h00; // [R10]
					fl_set[QTC_FL_T1] = 1'b1; // [R10]
				end else begin
					nxt_st.timer_one_count = st_ff.timer_one_count + 8'h01;
				end
			end
			if (t2_ev) begin
				if (st_ff.timer_two_count == st_ff.timer_two_period) begin
					nxt_st.timer_two_count = 8'h00; // [R11]
					fl_set[QTC_FL_T2] = 1'b1; // [R11]
				end else begin
					nxt_st.timer_two_count = st_ff.timer_two_count + 8'h01;
				end
			end
		end

		// --------------------------------------------------------
		// Timer three
		// --------------------------------------------------------
		// Timer three: own pin or tick; free run to FFFFh in dual capture
		dual = st_ff.tctl[QTC_TC_DUAL];
		t3_ev = st_ff.tctl[QTC_TC_T3_ON] &&
			(st_ff.tctl[QTC_TC_T3_EXT] ? rise[2] : tick); // [R15]
		t3_lim = dual ? 16'hffff : st_ff.timer_three_period; // [R16]
		if (t3_ev) begin
			if (st_ff.timer_three_count == t3_lim) begin
				nxt_st.timer_three_count = 16'h0000; // [R14]
				fl_set[QTC_FL_T3] = 1'b1; // [R14]
			end else begin
				nxt_st.timer_three_count = st_ff.timer_three_count + 16'h0001;
			end
		end

		// --------------------------------------------------------
		// Captures
		// --------------------------------------------------------
		// Input captures on rising edges take timer three's count
		if (rise[1]) begin
			nxt_st.capture_one = st_ff.timer_three_count; // [R17]
			fl_set[QTC_FL_CAP1] = 1'b1;
		end
		if (rise[0] && dual) begin
			nxt_st.timer_three_period = st_ff.timer_three_count; // [R16]
			fl_set[QTC_FL_CAP2] = 1'b1;
		end

		// --------------------------------------------------------
		// Pulse outputs
		// --------------------------------------------------------
		// Pulse outputs high while the time base is below the duty value
		nxt_st.pwm[0] = st_ff.timer_one_count < st_ff.duty1; // [R17]
		nxt_st.pwm[1] = st_ff.timer_two_count < st_ff.duty2; // [R17]

		// --------------------------------------------------------
		// Register writes
		// --------------------------------------------------------
		// Register writes; a count write overrides that cycle's increment
		if (bus_i.we) begin
			unique case (bus_i.addr)
				QTC_ADR_T0_CTL: nxt_st.ctl0 = bus_i.wdata & QTC_CTL_MASK;
				QTC_ADR_INTERRUPT_STATUS_ENABLE: nxt_st.interrupt_status_enable = bus_i.wdata;
				QTC_ADR_T0_LO: nxt_st.timer_zero_count[7:0] = bus_i.wdata;
				QTC_ADR_T0_HI: nxt_st.timer_zero_count[15:8] = bus_i.wdata;
				QTC_ADR_T1_CNT: nxt_st.timer_one_count = bus_i.wdata;
				QTC_ADR_T1_PER: nxt_st.timer_one_period = bus_i.wdata;
				QTC_ADR_T2_CNT: nxt_st.timer_two_count = bus_i.wdata;
				QTC_ADR_T2_PER: nxt_st.timer_two_period = bus_i.wdata;
				QTC_ADR_T3_LO: nxt_st.timer_three_count[7:0] = bus_i.wdata;
				QTC_ADR_T3_HI: nxt_st.timer_three_count[15:8] = bus_i.wdata;
				QTC_ADR_P3_LO: nxt_st.timer_three_period[7:0] = bus_i.wdata;
				QTC_ADR_P3_HI: nxt_st.timer_three_period[15:8] = bus_i.wdata;
				QTC_ADR_TCTL: nxt_st.tctl = bus_i.wdata;
				QTC_ADR_TFLG: fl_clr = bus_i.wdata & QTC_FL_MASK;
				QTC_ADR_TEN: nxt_st.ten = bus_i.wdata & QTC_FL_MASK;
				QTC_ADR_DUTY1: nxt_st.duty1 = bus_i.wdata;
				QTC_ADR_DUTY2: nxt_st.duty2 = bus_i.wdata;
				default: ;
			endcase
		end

		// A timer zero write restarts the prescaler at a clean phase
		t0_wr = bus_i.we && (bus_i.addr == QTC_ADR_T0_CTL ||
			bus_i.addr == QTC_ADR_T0_LO || bus_i.addr == QTC_ADR_T0_HI);
		if (t0_wr) begin
			nxt_st.pre = 8'h00;
		end

		// --------------------------------------------------------
		// Flags
		// --------------------------------------------------------
		// Vector acknowledge clears the overflow flag; a new overflow wins
		if (t0_vector_ack_i) begin
			nxt_st.interrupt_status_enable[QTC_INT_TIMER_ZERO_OVERFLOW_FLAG] = 1'b0; // [R7]
		end
		if (t0_ovf) begin
			nxt_st.interrupt_status_enable[QTC_INT_TIMER_ZERO_OVERFLOW_FLAG] = 1'b1; // [R5] [R6]
		end

		// Write-one-to-clear flags, set wins over clear
		nxt_st.tflg = (st_ff.tflg & ~fl_clr) | fl_set;

		// --------------------------------------------------------
		// Read data
		// --------------------------------------------------------
		// Read data stand one cycle after the read strobe
		nxt_st.rdata = 8'h00;
		if (bus_i.re) begin
			unique case (bus_i.addr)
				QTC_ADR_T0_CTL: nxt_st.rdata = st_ff.ctl0;
				QTC_ADR_INTERRUPT_STATUS_ENABLE: nxt_st.rdata = st_ff.interrupt_status_enable;
				QTC_ADR_T0_LO: nxt_st.rdata = st_ff.timer_zero_count[7:0];
				QTC_ADR_T0_HI: nxt_st.rdata = st_ff.timer_zero_count[15:8];
				QTC_ADR_T1_CNT: nxt_st.rdata = st_ff.timer_one_count;
				QTC_ADR_T1_PER: nxt_st.rdata = st_ff.timer_one_period;
				QTC_ADR_T2_CNT: nxt_st.rdata = st_ff.timer_two_count;
				QTC_ADR_T2_PER: nxt_st.rdata = st_ff.timer_two_period;
				QTC_ADR_T3_LO: nxt_st.rdata = st_ff.timer_three_count[7:0];
				QTC_ADR_T3_HI: nxt_st.rdata = st_ff.timer_three_count[15:8];
				QTC_ADR_P3_LO: nxt_st.rdata = st_ff.timer_three_period[7:0];
				QTC_ADR_P3_HI: nxt_st.rdata = st_ff.timer_three_period[15:8];
				QTC_ADR_C1_LO: nxt_st.rdata = st_ff.capture_one[7:0];
				QTC_ADR_C1_HI: nxt_st.rdata = st_ff.capture_one[15:8];
				QTC_ADR_TCTL: nxt_st.rdata = st_ff.tctl;
				QTC_ADR_TFLG: nxt_st.rdata = st_ff.tflg;
				QTC_ADR_TEN: nxt_st.rdata = st_ff.ten;
				QTC_ADR_DUTY1: nxt_st.rdata = st_ff.duty1;
				QTC_ADR_DUTY2: nxt_st.rdata = st_ff.duty2;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Every field restarts at a fixed value; pin levels idle low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff.q <= 2'h0;
			st_ff.ctl0 <= QTC_CTL_RST;
			st_ff.interrupt_status_enable <= QTC_INTERRUPT_STATUS_ENABLE_RST;
			st_ff.timer_zero_count <= 16'h0000;
			st_ff.pre <= 8'h00;
			st_ff.prescaler_output <= 1'b0;
			st_ff.psync <= 1'b0;
			st_ff.samp <= 1'b0;
			st_ff.pins_prev <= 5'h00;
			st_ff.timer_one_count <= 8'h00;
			st_ff.timer_two_count <= 8'h00;
			st_ff.timer_one_period <= QTC_PER8_RST;
			st_ff.timer_two_period <= QTC_PER8_RST;
			st_ff.timer_three_count <= 16'h0000;
			st_ff.timer_three_period <= QTC_PER16_RST;
			st_ff.capture_one <= 16'h0000;
			st_ff.tctl <= QTC_TCTL_RST;
			st_ff.tflg <= 8'h00;
			st_ff.ten <= 8'h00;
			st_ff.duty1 <= 8'h00;
			st_ff.duty2 <= 8'h00;
			st_ff.pwm <= 2'h0;
			st_ff.rdata <= 8'h00;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Requests gated by their enables; flags set regardless
	assign irq_o[0] = st_ff.interrupt_status_enable[QTC_INT_TIMER_ZERO_OVERFLOW_FLAG] &
		st_ff.interrupt_status_enable[QTC_INT_TIMER_ZERO_IRQ_ENABLE]; // [R6]
	// Timers one to three; captures share timer three's request
	assign irq_o[1] = st_ff.tflg[QTC_FL_T1] & st_ff.ten[QTC_FL_T1]; // [R10]
	assign irq_o[2] = st_ff.tflg[QTC_FL_T2] & st_ff.ten[QTC_FL_T2]; // [R11]
	assign irq_o[3] = |(st_ff.tflg[4:2] & st_ff.ten[4:2]); // [R14]
	// Data outputs straight from flip-flops
	assign rdata_o = st_ff.rdata;
	assign pwm_o = st_ff.pwm;

endmodule // qtc_timers

`default_nettype wire

// >>> bench/qtc_timers_assertions.sv
// Purpose: Port checks of the timer set
// Assumes: Control and enable bits mirrored from bus writes
// Notes: Bound to qtc_timers
`timescale 1ns/1ps
`default_nettype none
module qtc_timers_assertions
	import qtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire qtc_bus_t bus_i,
	input wire logic t0_vector_ack_i,
	input wire logic [7:0] rdata_o,
	input wire logic [3:0] irq_o
);
	logic [7:0] ctl_ff;
	logic ie_ff;
	logic [7:0] en_ff;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Mirror of software-written bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl_ff <= 8'h00;
			ie_ff <= 1'b0;
			en_ff <= 8'h00;
		end else if (bus_i.we) begin
			if (bus_i.addr == QTC_ADR_T0_CTL) begin
				ctl_ff <= bus_i.wdata & QTC_CTL_MASK;
			end
			if (bus_i.addr == QTC_ADR_INTERRUPT_STATUS_ENABLE) begin
				ie_ff <= bus_i.wdata[QTC_INT_TIMER_ZERO_IRQ_ENABLE];
			end
			if (bus_i.addr == QTC_ADR_TEN) begin
				en_ff <= bus_i.wdata;
			end
		end
	end
	// Read port answers
	a_rd_idle_zero:
		assert property (!bus_i.re |=> rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_zero:
		assert property (bus_i.re && bus_i.addr == 8'h06 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_ctl_readback:
		assert property (bus_i.re && bus_i.addr == QTC_ADR_T0_CTL
			|=> rdata_o == ctl_ff)
		else $error("control readback wrong");
	// Interrupt requests
	a_t0_mask:
		assert property (!ie_ff |-> !irq_o[0])
		else $error("timer zero request while disabled");
	a_t0_ack_clear:
		assert property (t0_vector_ack_i |=> !irq_o[0])
		else $error("vector did not clear timer zero flag");
	a_t0_flag_holds:
		assert property (irq_o[0] && !t0_vector_ack_i
			&& !(bus_i.we && bus_i.addr == QTC_ADR_INTERRUPT_STATUS_ENABLE) |=> irq_o[0])
		else $error("timer zero flag dropped by itself");
	a_t1_mask:
		assert property (!en_ff[QTC_FL_T1] |-> !irq_o[1])
		else $error("timer one request while disabled");
	a_t3_mask:
		assert property (en_ff[4:2] == 3'h0 |-> !irq_o[3])
		else $error("timer three request while disabled");
endmodule // qtc_timers_assertions
bind qtc_timers qtc_timers_assertions chk_u (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.bus_i(bus_i),
	.t0_vector_ack_i(t0_vector_ack_i),
	.rdata_o(rdata_o),
	.irq_o(irq_o)
);
`default_nettype wire

// >>> bench/qtc_count_source.sv
// Purpose: Pulse source for the external count pins
// Assumes: Pulses are 4 clocks high, 4 low; pins idle low
// Notes: Selection three pulses both capture inputs together
`timescale 1ns/1ps
`default_nettype none
module qtc_count_source
	import qtc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic [1:0] sel_i,
	input wire logic [15:0] num_i,
	output qtc_pins_t pins_o,
	output logic busy_o
);
	logic [15:0] left_ff;
	logic [2:0] ph_ff;
	logic lvl;
	// Pulses left and phase within a pulse
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left_ff <= 16'h0000;
			ph_ff <= 3'h0;
		end else if (go_i) begin
			left_ff <= num_i;
			ph_ff <= 3'h0;
		end else if (busy_o) begin
			ph_ff <= ph_ff + 3'h1;
			if (ph_ff == 3'h7) begin
				left_ff <= left_ff - 16'h0001;
			end
		end
	end
	// Only the selected pin moves; selection three moves both capture pins
	always_comb begin
		busy_o = left_ff != 16'h0000;
		lvl = busy_o && !ph_ff[2];
		pins_o = '0;
		pins_o.timer_zero_count_pin = lvl && sel_i == 2'h0;
		pins_o.shared_count_pin = lvl && sel_i == 2'h1;
		pins_o.timer_three_count_pin = lvl && sel_i == 2'h2;
		pins_o.capture_one_pin = lvl && sel_i == 2'h3;
		pins_o.capture_two_pin = lvl && sel_i == 2'h3;
	end
endmodule // qtc_count_source
`default_nettype wire

// >>> bench/quad_timer_counter_set_test.sv
// Purpose: Self-checking bench of the timer set
// Assumes: Pins come from qtc_count_source
// Notes: Prescaled counts allow one count of slack
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module quad_timer_counter_set_test
	import qtc_pkg::*;
;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic ack = 1'b0;
	logic go = 1'b0;
	logic [1:0] sel = 2'h0;
	logic [15:0] num = 16'h0000;
	qtc_bus_t bus = '0;
	qtc_pins_t pins;
	logic busy;
	logic [7:0] rdata;
	logic [7:0] v;
	logic [3:0] irq;
	logic [1:0] pwm;
	int n_errors = 0;
	int cmp_count = 0;
	logic [15:0] rst_tab [8] = '{16'h0500, 16'h0700, 16'h11ff,
		16'h13ff, 16'h16ff, 16'h17ff, 16'h1a00, 16'h0600};
	logic [3:0] ps_tab [4] = '{4'h0, 4'h3, 4'h8, 4'hf};
	// Clock and instances
	always #5 clk_i = ~clk_i;
	qtc_timers dut_u (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
		.pins_i(pins), .t0_vector_ack_i(ack), .rdata_o(rdata),
		.irq_o(irq), .pwm_o(pwm));
	qtc_count_source src_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go),
		.sel_i(sel), .num_i(num), .pins_o(pins), .busy_o(busy));
	// Register port cycles
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.we <= 1'b1;
		@(posedge clk_i);
		bus.we <= 1'b0;
	endtask
	task automatic rdv(input logic [7:0] a, output logic [7:0] q);
		@(posedge clk_i);
		bus.addr <= a;
		bus.re <= 1'b1;
		@(posedge clk_i);
		bus.re <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rdv(a, v);
		`CHK(v, e)
	endtask
	// Pin pulses, then time for synchronising
	task automatic pulse(input logic [1:0] s, input logic [15:0] n);
		int i;
		@(posedge clk_i);
		go <= 1'b1;
		sel <= s;
		num <= n;
		@(posedge clk_i);
		go <= 1'b0;
		#1;
		for (i = 0; i < 4000 && busy !== 1'b0; i++) begin
			@(posedge clk_i);
		end
		repeat (8) @(posedge clk_i);
	endtask
	task automatic t0_start(input logic [7:0] c);
		wr(8'h05, 8'h00);
		wr(8'h0b, 8'h00);
		wr(8'h0c, 8'h00);
		wr(8'h05, c);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (30000) @(posedge clk_i);
		n_errors++;
		report_and_stop();
	end
	// Test sequence
	initial begin
		int k;
		int n;
		int sh;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		for (k = 0; k < 8; k++) begin
			rd(rst_tab[k][15:8], rst_tab[k][7:0]);
		end
		wr(8'h05, 8'hff);
		rd(8'h05, 8'hfe);
		wr(8'h1f, 8'h55);
		rd(8'h1f, 8'h00);
		$display("test reset done");
		for (k = 0; k < 4; k++) begin
			n = (ps_tab[k] >= 4'h8) ? 3 : 10;
			sh = (ps_tab[k] >= 4'h8) ? 8 : ps_tab[k];
			t0_start({3'b001, ps_tab[k], 1'b0});
			repeat ((4 * n) << sh) @(posedge clk_i);
			wr(8'h05, 8'h00);
			rdv(8'h0b, v);
			`CHK(v >= n - 1 && v <= n + 1, 1'b1)
		end
		$display("test prescale done");
		wr(8'h07, 8'h00);
		wr(8'h0b, 8'hfe);
		wr(8'h0c, 8'hff);
		wr(8'h05, 8'h20);
		repeat (24) @(posedge clk_i);
		wr(8'h05, 8'h00);
		rd(8'h07, 8'h20);
		`CHK(irq[0], 1'b0)
		wr(8'h07, 8'h22);
		#1 `CHK(irq[0], 1'b1)
		@(posedge clk_i);
		ack <= 1'b1;
		@(posedge clk_i);
		ack <= 1'b0;
		#1 `CHK(irq[0], 1'b0)
		rd(8'h07, 8'h02);
		$display("test overflow done");
		t0_start(8'h40);
		pulse(2'h0, 16'h0005);
		rd(8'h0b, 8'h05);
		t0_start(8'h00);
		pulse(2'h0, 16'h0005);
		rd(8'h0b, 8'h05);
		$display("test pin done");
		wr(8'h11, 8'h03);
		wr(8'h13, 8'h05);
		wr(8'h10, 8'h00);
		wr(8'h12, 8'h00);
		wr(8'h1b, 8'h1f);
		wr(8'h1c, 8'h01);
		wr(8'h1a, 8'h63);
		pulse(2'h1, 16'h0004);
		rd(8'h10, 8'h00);
		rd(8'h12, 8'h04);
		rd(8'h1b, 8'h01);
		`CHK(irq[1], 1'b1)
		wr(8'h1b, 8'h01);
		#1 `CHK(irq[1], 1'b0)
		wr(8'h1d, 8'h01);
		wr(8'h1e, 8'h04);
		@(posedge clk_i);
		#1 `CHK(pwm, 2'h1)
		wr(8'h1a, 8'h00);
		wr(8'h11, 8'h02);
		wr(8'h13, 8'h01);
		wr(8'h10, 8'h00);
		wr(8'h12, 8'h00);
		wr(8'h1a, 8'h25);
		pulse(2'h1, 16'h0102);
		rd(8'h10, 8'h02);
		rd(8'h12, 8'h01);
		rd(8'h1b, 8'h00);
		pulse(2'h1, 16'h0001);
		rd(8'h10, 8'h00);
		rd(8'h12, 8'h00);
		rd(8'h1b, 8'h01);
		$display("test timers one two done");
		wr(8'h1a, 8'h00);
		wr(8'h1b, 8'h1f);
		wr(8'h16, 8'h02);
		wr(8'h17, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h15, 8'h00);
		wr(8'h1c, 8'h04);
		wr(8'h1a, 8'h88);
		pulse(2'h2, 16'h0003);
		rd(8'h14, 8'h00);
		rd(8'h1b, 8'h04);
		`CHK(irq[3], 1'b1)
		$display("test timer three done");
		wr(8'h1a, 8'h00);
		wr(8'h1b, 8'h1f);
		wr(8'h14, 8'h34);
		wr(8'h15, 8'h12);
		wr(8'h1a, 8'h10);
		pulse(2'h3, 16'h0001);
		rd(8'h18, 8'h34);
		rd(8'h19, 8'h12);
		rd(8'h16, 8'h34);
		rd(8'h17, 8'h12);
		rd(8'h1b, 8'h18);
		$display("test capture done");
		report_and_stop();
	end
endmodule // quad_timer_counter_set_test
`default_nettype wire
